// *** inc/fsu_pkg.sv ***
// Purpose: Shared constants and types for the flash security release sequencer.
// Assumes: Word-aligned byte addresses on a classic Wishbone bus with 32-bit data.
// Notes: Every offset, command code and encoding lives here, and every bit position except the protection open bit 0 and the index field bits 2:0.
`default_nettype none
package fsu_pkg;
    // Register byte offsets.
    localparam logic [7:0] REG_STAT = 8'h00;
    localparam logic [7:0] REG_INDEX = 8'h04;
    localparam logic [7:0] REG_OBJ = 8'h08;
    localparam logic [7:0] REG_SEC = 8'h0c;
    localparam logic [7:0] REG_PROT = 8'h10;
    localparam logic [7:0] REG_ISTAT = 8'h14;
    localparam logic [7:0] REG_IMASK = 8'h18;
    // Bit positions in the flash status register.
    localparam int STB_COMMAND_COMPLETE_FLAG = 7;
    localparam int STB_ACCESS_ERROR_FLAG = 5;
    localparam int STB_PROTECTION_VIOLATION_FLAG = 4;
    localparam int STB_VERR = 1;
    localparam int STB_UVERR = 0;
    // Bit positions in the interrupt status and mask registers.
    localparam int IRQ_DONE = 0;
    localparam int IRQ_ACCESS_ERROR_FLAG = 1;
    localparam int IRQ_PROTECTION_VIOLATION_FLAG = 2;
    localparam int IRQ_VERR = 3;
    localparam int IRQ_W = 4;
    // Field positions in the lock config register read-back and security byte.
    localparam int SEC_LOCK_LSB = 0;
    localparam int SEC_BACKDOOR_KEY_ENABLE_LSB = 2;
    localparam int SEC_LOCKOUT = 4;
    localparam int SECB_LOCK_LSB = 0;
    localparam int SECB_BACKDOOR_KEY_ENABLE_LSB = 6;
    // Command codes, carried in the high byte of command object word 0.
    localparam logic [7:0] CMD_UNSECURE = 8'h0b;
    localparam logic [7:0] CMD_KEY = 8'h0c;
    // Command object index required at launch.
    localparam logic [2:0] IDX_UNSECURE = 3'h0;
    localparam logic [2:0] IDX_KEY = 3'h4;
    // Encodings.
    localparam logic [1:0] BACKDOOR_KEY_ENABLE_ON = 2'h2;
    localparam logic [1:0] LOCK_OPEN = 2'h2;
    localparam logic [15:0] KEY_BAD_LO = 16'h0000;
    localparam logic [15:0] KEY_BAD_HI = 16'hffff;
    // Sequencer states.
    typedef enum logic [1:0] {
        S_IDLE = 2'b00,
        S_ERASE = 2'b01,
        S_VERIFY = 2'b10,
        S_KEYCHK = 2'b11
    } fsu_state_e;
endpackage
`default_nettype wire

// *** src/fsu_flash_security_unlock.sv ***
// Purpose: Command sequencer that releases flash security by unsecure or by backdoor key.
// Assumes: The flash array engine and mode logic run on clk_i; the security byte is stable after reset.
// Notes: Registers sit on a classic Wishbone slave that answers one cycle after a request.
//
// Added by the designer: the Wishbone register port and the register offsets.
`default_nettype none
// How it works
// - Unsecure command erases all flash, then verifies.
// - Verify pass releases the security lock.
// - Verify fail sets error, keeps lock state.
// - Completion flag sets when unsecure finishes.
// - Index not zero at launch is access error.
// - Unsecure in forbidden mode is access error.
// - Any protected region gives protection violation.
// - Verify errors set error flag; fatal ones also set uncorrectable.
// - Key command runs only when keys enabled.
// - Four matching keys force lock state 10.
// - Keys 0000 and ffff never match.
// - Block 0 reads invalid during key check.
// - Key mismatch locks out key command until reset.
// - Key success leaves security byte untouched.
// - Keys and protection settings stay unchanged.
// - Full erase needs all protection opened first.
module fsu_flash_security_unlock
    import fsu_pkg::*;
#(
    parameter int NUM_KEYS = 4,
    parameter int KEY_W = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic mode_unsec_ok_i,
    input wire logic [7:0] sec_byte_i,
    input wire logic [NUM_KEYS*KEY_W-1:0] stored_keys_i,
    output logic erase_req_o,
    input wire logic erase_done_i,
    output logic verify_req_o,
    input wire logic verify_done_i,
    input wire logic verify_err_i,
    input wire logic verify_fatal_i,
    output logic pflash0_busy_o,
    output logic [1:0] lock_state_o,
    output logic irq_o
);
    // Bus side state.
    logic ack_reg; // Registered acknowledge, high for one cycle.
    logic [31:0] rdata_reg; // Registered read data.
    // Flash status flags.
    logic command_complete_flag_reg; // Command complete; low while a command runs.
    logic access_error_flag_reg; // Access error, write one to clear.
    logic protection_violation_flag_reg; // Protection violation, write one to clear.
    logic verr_reg; // Verify error, cleared at next launch.
    logic uverr_reg; // Uncorrectable verify error, cleared at next launch.
    // Command objects and index.
    logic [2:0] index_reg; // Command object index.
    logic [KEY_W-1:0] obj_reg [0:NUM_KEYS]; // Command object words.
    // Security state.
    logic loaded_reg; // Security byte captured since reset.
    logic [1:0] lock_reg; // Protection lock state.
    logic [1:0] backdoor_key_enable_reg; // Backdoor key enable field.
    logic lockout_reg; // Key command barred until reset.
    logic prot_open_reg; // All protection disable and open bits set.
    // Interrupt state.
    logic [IRQ_W-1:0] istat_reg; // Sticky events.
    logic [IRQ_W-1:0] imask_reg; // Event enables.
    logic irq_reg; // Registered interrupt level.
    // Sequencer.
    fsu_state_e state_reg;
    fsu_state_e state_next;
    logic erase_req_reg;
    logic verify_req_reg;
    logic busy_reg;

    // Request decode; a write takes effect only in its ack cycle.
    logic req;
    logic wr;
    logic wr_stat;
    logic clr_acc;
    logic clr_fp;
    logic launch;
    logic [7:0] cmd;
    logic [NUM_KEYS-1:0] key_ok;
    logic keys_match;
    assign req = wb_cyc_i && wb_stb_i;
    assign wr = req && wb_we_i && ack_reg;
    assign wr_stat = wr && wb_adr_i == REG_STAT && wb_sel_i[0];
    assign clr_acc = wr_stat && wb_dat_i[STB_ACCESS_ERROR_FLAG];
    assign clr_fp = wr_stat && wb_dat_i[STB_PROTECTION_VIOLATION_FLAG];
    // A launch is ignored while an access or protection error flag stays pending.
    assign launch = wr_stat && wb_dat_i[STB_COMMAND_COMPLETE_FLAG] && command_complete_flag_reg
        && !(access_error_flag_reg && !clr_acc) && !(protection_violation_flag_reg && !clr_fp);
    assign cmd = obj_reg[0][KEY_W-1:KEY_W-8];

    // Per-key comparison; reserved key values never count as a match.
    genvar gi;
    generate
        for (gi = 0; gi < NUM_KEYS; gi++) begin : g_key
            logic [KEY_W-1:0] stored;
            assign stored = stored_keys_i[gi*KEY_W +: KEY_W];
            assign key_ok[gi] = obj_reg[gi+1] == stored
                && stored != KEY_BAD_LO && stored != KEY_BAD_HI;
        end
    endgenerate
    assign keys_match = &key_ok;

    // Launch checks, decided in one place so flags and state agree.
    logic go_unsec;
    logic go_key;
    logic err_acc;
    logic err_fp;
    always_comb begin
        go_unsec = 1'b0;
        go_key = 1'b0;
        err_acc = 1'b0;
        err_fp = 1'b0;
        if (launch) begin
            if (cmd == CMD_UNSECURE) begin
                if (index_reg != IDX_UNSECURE || !mode_unsec_ok_i) begin
                    err_acc = 1'b1;
                end else if (!prot_open_reg) begin
                    err_fp = 1'b1;
                end else begin
                    go_unsec = 1'b1;
                end
            end else if (cmd == CMD_KEY) begin
                // Lockout holds until reset, so an enabled field alone is not enough.
                if (index_reg != IDX_KEY || backdoor_key_enable_reg != BACKDOOR_KEY_ENABLE_ON || lockout_reg) begin
                    err_acc = 1'b1;
                end else begin
                    go_key = 1'b1;
                end
            end else begin
                err_acc = 1'b1;
            end
        end
    end

    // Next state of the sequencer.
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            S_IDLE: begin
                if (go_unsec) begin
                    state_next = S_ERASE;
                end else if (go_key) begin
                    state_next = S_KEYCHK;
                end
            end
            S_ERASE: begin
                if (erase_done_i) begin
                    state_next = S_VERIFY;
                end
            end
            S_VERIFY: begin
                if (verify_done_i) begin
                    state_next = S_IDLE;
                end
            end
            S_KEYCHK: begin
                state_next = S_IDLE;
            end
            default: begin
                state_next = S_IDLE;
            end
        endcase
    end

    // State and the array handshakes; outputs are flops decoded from the next state.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= S_IDLE;
            erase_req_reg <= 1'b0;
            verify_req_reg <= 1'b0;
            busy_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            erase_req_reg <= state_next == S_ERASE;
            verify_req_reg <= state_next == S_VERIFY;
            busy_reg <= state_next == S_KEYCHK;
        end
    end

    // Status flags; a hardware set wins over a same-cycle software clear.
    logic finish;
    logic verify_fail;
    assign verify_fail = state_reg == S_VERIFY && verify_done_i && (verify_err_i || verify_fatal_i);
    assign finish = (state_reg == S_VERIFY && verify_done_i) || state_reg == S_KEYCHK;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            command_complete_flag_reg <= 1'b1;
            access_error_flag_reg <= 1'b0;
            protection_violation_flag_reg <= 1'b0;
            verr_reg <= 1'b0;
            uverr_reg <= 1'b0;
        end else begin
            if (go_unsec || go_key) begin
                command_complete_flag_reg <= 1'b0;
            end else if (finish) begin
                command_complete_flag_reg <= 1'b1;
            end
            access_error_flag_reg <= err_acc || (access_error_flag_reg && !clr_acc);
            protection_violation_flag_reg <= err_fp || (protection_violation_flag_reg && !clr_fp);
            if (go_unsec || go_key) begin
                verr_reg <= 1'b0;
                uverr_reg <= 1'b0;
            end else if (verify_fail) begin
                verr_reg <= 1'b1;
                uverr_reg <= verify_fatal_i;
            end
        end
    end

    // Security state. The byte is sampled after reset and never written back.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            loaded_reg <= 1'b0;
            lock_reg <= 2'h0;
            backdoor_key_enable_reg <= 2'h0;
            lockout_reg <= 1'b0;
        end else begin
            if (!loaded_reg) begin
                loaded_reg <= 1'b1;
                lock_reg <= sec_byte_i[SECB_LOCK_LSB +: 2];
                backdoor_key_enable_reg <= sec_byte_i[SECB_BACKDOOR_KEY_ENABLE_LSB +: 2];
            end else if (state_reg == S_VERIFY && verify_done_i && !verify_fail) begin
                lock_reg <= LOCK_OPEN;
            end else if (state_reg == S_KEYCHK && keys_match) begin
                lock_reg <= LOCK_OPEN;
            end
            if (state_reg == S_KEYCHK && !keys_match) begin
                lockout_reg <= 1'b1;
            end
        end
    end

    // Software registers. Keys and protection are never touched by the sequence.
    // Writes while a command runs are the caller's fault and are simply taken.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            index_reg <= 3'h0;
            prot_open_reg <= 1'b0;
            imask_reg <= '0;
            for (int i = 0; i <= NUM_KEYS; i++) begin
                obj_reg[i] <= '0;
            end
        end else if (wr && wb_sel_i[0]) begin
            case (wb_adr_i)
                REG_INDEX: index_reg <= wb_dat_i[2:0];
                REG_PROT: prot_open_reg <= wb_dat_i[0];
                REG_IMASK: imask_reg <= wb_dat_i[IRQ_W-1:0];
                REG_OBJ: begin
                    if (int'(index_reg) <= NUM_KEYS && wb_sel_i[1]) begin
                        obj_reg[index_reg] <= wb_dat_i[KEY_W-1:0];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Interrupt events, write one to clear, set wins.
    logic [IRQ_W-1:0] ev;
    logic [IRQ_W-1:0] iclr;
    always_comb begin
        ev = '0;
        ev[IRQ_DONE] = finish;
        ev[IRQ_ACCESS_ERROR_FLAG] = err_acc;
        ev[IRQ_PROTECTION_VIOLATION_FLAG] = err_fp;
        ev[IRQ_VERR] = verify_fail;
        iclr = '0;
        if (wr && wb_sel_i[0] && wb_adr_i == REG_ISTAT) begin
            iclr = wb_dat_i[IRQ_W-1:0];
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            istat_reg <= '0;
            irq_reg <= 1'b0;
        end else begin
            istat_reg <= ev | (istat_reg & ~iclr);
            irq_reg <= |((ev | (istat_reg & ~iclr)) & imask_reg);
        end
    end

    // Bus answer: ack one cycle after a request, dropped the cycle after.
    logic [31:0] rd;
    always_comb begin
        rd = '0;
        case (wb_adr_i)
            REG_STAT: begin
                rd[STB_COMMAND_COMPLETE_FLAG] = command_complete_flag_reg;
                rd[STB_ACCESS_ERROR_FLAG] = access_error_flag_reg;
                rd[STB_PROTECTION_VIOLATION_FLAG] = protection_violation_flag_reg;
                rd[STB_VERR] = verr_reg;
                rd[STB_UVERR] = uverr_reg;
            end
            REG_INDEX: rd[2:0] = index_reg;
            REG_OBJ: begin
                if (int'(index_reg) <= NUM_KEYS) begin
                    rd[KEY_W-1:0] = obj_reg[index_reg];
                end
            end
            REG_SEC: begin
                rd[SEC_LOCK_LSB +: 2] = lock_reg;
                rd[SEC_BACKDOOR_KEY_ENABLE_LSB +: 2] = backdoor_key_enable_reg;
                rd[SEC_LOCKOUT] = lockout_reg;
            end
            REG_PROT: rd[0] = prot_open_reg;
            REG_ISTAT: rd[IRQ_W-1:0] = istat_reg;
            REG_IMASK: rd[IRQ_W-1:0] = imask_reg;
            default: rd = '0;
        endcase
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            rdata_reg <= '0;
        end else begin
            ack_reg <= req && !ack_reg;
            rdata_reg <= (req && !ack_reg) ? rd : '0;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdata_reg;
    assign erase_req_o = erase_req_reg;
    assign verify_req_o = verify_req_reg;
    assign pflash0_busy_o = busy_reg;
    assign lock_state_o = lock_reg;
    assign irq_o = irq_reg;

    // Checks next to the logic they guard.
    sequence s_unsec_go;
        go_unsec;
    endsequence
    sequence s_verify_end;
        state_reg == S_VERIFY && verify_done_i;
    endsequence
    a_unsec_erase: assert property (@(posedge clk_i) disable iff (rst_i)
        s_unsec_go |=> erase_req_o && !command_complete_flag_reg)
        else $error("unsecure launch did not start erase");
    a_erase_verify: assert property (@(posedge clk_i) disable iff (rst_i)
        erase_req_o && erase_done_i |=> verify_req_o && !erase_req_o)
        else $error("verify did not follow erase");
    a_verify_unlock: assert property (@(posedge clk_i) disable iff (rst_i)
        s_verify_end ##0 !verify_err_i && !verify_fatal_i |=> lock_state_o == LOCK_OPEN)
        else $error("passed verify did not release lock");
    a_verify_fail: assert property (@(posedge clk_i) disable iff (rst_i)
        s_verify_end ##0 verify_err_i |=> verr_reg && $stable(lock_reg) && command_complete_flag_reg)
        else $error("failed verify changed lock or missed flag");
    a_fatal_flag: assert property (@(posedge clk_i) disable iff (rst_i)
        s_verify_end ##0 verify_fatal_i |=> verr_reg && uverr_reg)
        else $error("uncorrectable verify not flagged");
    a_done_flag: assert property (@(posedge clk_i) disable iff (rst_i)
        s_verify_end |=> command_complete_flag_reg ##1 !verify_req_o)
        else $error("completion flag not set");
    a_index_err: assert property (@(posedge clk_i) disable iff (rst_i)
        launch && cmd == CMD_UNSECURE && index_reg != IDX_UNSECURE |=> access_error_flag_reg && state_reg == S_IDLE)
        else $error("bad index not refused");
    a_prot_err: assert property (@(posedge clk_i) disable iff (rst_i)
        err_fp |=> protection_violation_flag_reg && !erase_req_o)
        else $error("protected flash erase not refused");
    a_key_gate: assert property (@(posedge clk_i) disable iff (rst_i)
        launch && cmd == CMD_KEY && (backdoor_key_enable_reg != BACKDOOR_KEY_ENABLE_ON || lockout_reg) |=> !pflash0_busy_o)
        else $error("disabled key command ran");
    a_key_match: assert property (@(posedge clk_i) disable iff (rst_i)
        state_reg == S_KEYCHK && keys_match |=> lock_state_o == LOCK_OPEN && pflash0_busy_o == 1'b0)
        else $error("matching keys did not unlock");
    a_key_lockout: assert property (@(posedge clk_i) disable iff (rst_i)
        state_reg == S_KEYCHK && !keys_match |=> lockout_reg && $stable(lock_reg) ##1 lockout_reg)
        else $error("mismatch did not lock out");
endmodule
`default_nettype wire

// *** verification/fsu_tb.sv ***
// Purpose: Self-checking bench for the flash security release sequencer.
// Assumes: Wishbone answers one cycle after a request; the complete flag is set out of reset.
// Notes: The bench plays the flash array itself, answering erase and verify requests.
`default_nettype none
module tb import fsu_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    // Good key set; key0 pairs with object word 1.
    localparam logic [63:0] KEYS = 64'hdef0_9abc_5678_1234;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic mode_unsec_ok_i = 1'b1;
    logic [7:0] sec_byte_i = 8'h81;
    logic [63:0] stored_keys_i = KEYS;
    logic erase_req_o;
    logic erase_done_i = 1'b0;
    logic verify_req_o;
    logic verify_done_i = 1'b0;
    logic verify_err_i = 1'b0;
    logic verify_fatal_i = 1'b0;
    logic pflash0_busy_o;
    logic [1:0] lock_state_o;
    logic irq_o;
    int fail_count = 0;
    int check_count = 0;
    int busy_cnt = 0;
    logic [31:0] rd;

    fsu_flash_security_unlock DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .mode_unsec_ok_i(mode_unsec_ok_i), .sec_byte_i(sec_byte_i),
        .stored_keys_i(stored_keys_i), .erase_req_o(erase_req_o), .erase_done_i(erase_done_i),
        .verify_req_o(verify_req_o), .verify_done_i(verify_done_i), .verify_err_i(verify_err_i),
        .verify_fatal_i(verify_fatal_i), .pflash0_busy_o(pflash0_busy_o), .lock_state_o(lock_state_o),
        .irq_o(irq_o));

    // A 100 ns clock period.
    initial begin
        forever #50 clk_i = ~clk_i;
    end

    // Counts cycles where block 0 reads are flagged invalid.
    always @(posedge clk_i) begin
        if (pflash0_busy_o === 1'b1) begin
            busy_cnt++;
        end
    end

    // Prints the counts and the verdict, then stops.
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // A wait that ran out counts as a mismatch and ends the run.
    task automatic timeout(input string what);
        fail_count++;
        $display("[FAIL] t=%0t timeout waiting for %s", $time, what);
        end_sim();
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One classic cycle; the request is held until ack is sampled high.
    // Two edges pass after the release, so that any output launched by the
    // write has settled before a caller compares it.
    task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int n;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'hf;
        wb_dat_i <= dat;
        for (n = 0; n < 20; n++) begin
            @(posedge clk_i);
            if (wb_ack_o === 1'b1) begin
                break;
            end
        end
        if (n == 20) begin
            timeout("ack");
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        @(posedge clk_i);
        @(posedge clk_i);
    endtask

    task automatic rchk(input logic [7:0] adr, input logic [31:0] exp);
        wb_cycle(1'b0, adr, 32'h0);
        chk(rd, exp);
    endtask

    // Loads one command object word at the given index.
    task automatic obj(input logic [2:0] idx, input logic [15:0] w);
        wb_cycle(1'b1, REG_INDEX, {29'h0, idx});
        wb_cycle(1'b1, REG_OBJ, {16'h0, w});
    endtask

    // Launch also clears stale access and protection errors in the same write.
    task automatic launch();
        wb_cycle(1'b1, REG_STAT, 32'h0000_00b0);
    endtask

    // Polls until the complete flag returns, with a bound.
    task automatic wait_done();
        int n;
        for (n = 0; n < 40; n++) begin
            wb_cycle(1'b0, REG_STAT, 32'h0);
            if (rd[STB_COMMAND_COMPLETE_FLAG] === 1'b1) begin
                return;
            end
        end
        timeout("complete");
    endtask

    // Waits for erase_req_o (sel 0) or verify_req_o (sel 1).
    task automatic wait_req(input int sel);
        int n;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_i);
            if ((sel == 0 ? erase_req_o : verify_req_o) === 1'b1) begin
                return;
            end
        end
        timeout("array request");
    endtask

    // Plays the array: finishes the erase, then reports the verify outcome.
    task automatic run_flash(input logic err, input logic fatal);
        wait_req(0);
        erase_done_i <= 1'b1;
        @(posedge clk_i);
        erase_done_i <= 1'b0;
        wait_req(1);
        chk(erase_req_o, 1'b0);
        verify_err_i <= err;
        verify_fatal_i <= fatal;
        verify_done_i <= 1'b1;
        @(posedge clk_i);
        verify_done_i <= 1'b0;
        verify_err_i <= 1'b0;
        verify_fatal_i <= 1'b0;
    endtask

    task automatic key_cmd(input logic [63:0] k);
        obj(3'h0, {CMD_KEY, 8'h00});
        for (int i = 1; i <= 4; i++) begin
            obj(3'(i), k[16*(i-1) +: 16]);
        end
        launch();
        wait_done();
    endtask

    // Reset is held six cycles; two idle cycles let the security byte load.
    task automatic do_reset();
        rst_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask

    initial begin
        int b0;
        do_reset();
        // Reset state and register map.
        chk(lock_state_o, 2'b01);
        rchk(REG_SEC, 32'h09);
        rchk(REG_PROT, 32'h0);
        rchk(REG_STAT, 32'h80);
        wb_cycle(1'b1, 8'h40, 32'hffff_ffff);
        rchk(8'h40, 32'h0);
        $display("test reset_map done");
        // Protection still closed: violation, no erase, masked interrupt.
        obj(3'h0, {CMD_UNSECURE, 8'h00});
        launch();
        wait_done();
        rchk(REG_STAT, 32'h90);
        chk(erase_req_o, 1'b0);
        wb_cycle(1'b0, REG_ISTAT, 32'h0);
        chk(rd[IRQ_PROTECTION_VIOLATION_FLAG], 1'b1);
        chk(irq_o, 1'b0);
        wb_cycle(1'b1, REG_IMASK, 32'h4);
        chk(irq_o, 1'b1);
        wb_cycle(1'b1, REG_ISTAT, 32'hf);
        chk(irq_o, 1'b0);
        wb_cycle(1'b1, REG_IMASK, 32'h0);
        $display("test protect done");
        // Wrong index, then forbidden mode, both refused.
        wb_cycle(1'b1, REG_PROT, 32'h1);
        obj(3'h0, {CMD_UNSECURE, 8'h00});
        wb_cycle(1'b1, REG_INDEX, 32'h1);
        launch();
        rchk(REG_STAT, 32'ha0);
        mode_unsec_ok_i <= 1'b0;
        obj(3'h0, {CMD_UNSECURE, 8'h00});
        launch();
        rchk(REG_STAT, 32'ha0);
        chk(erase_req_o, 1'b0);
        mode_unsec_ok_i <= 1'b1;
        $display("test refuse done");
        // Verify fails with an uncorrectable error: lock kept.
        launch();
        rchk(REG_STAT, 32'h0);
        run_flash(1'b1, 1'b1);
        wait_done();
        rchk(REG_STAT, 32'h83);
        chk(lock_state_o, 2'b01);
        // Verify passes: lock released, done interrupt raised.
        // Old events are cleared first, so only this run can raise the line.
        wb_cycle(1'b1, REG_ISTAT, 32'hf);
        wb_cycle(1'b1, REG_IMASK, 32'h1);
        chk(irq_o, 1'b0);
        launch();
        chk(irq_o, 1'b0);
        run_flash(1'b0, 1'b0);
        wait_done();
        rchk(REG_STAT, 32'h80);
        chk(lock_state_o, LOCK_OPEN);
        chk(irq_o, 1'b1);
        wb_cycle(1'b1, REG_ISTAT, 32'hf);
        chk(irq_o, 1'b0);
        $display("test unsecure done");
        // One bad key word locks the key command out until reset.
        do_reset();
        chk(lock_state_o, 2'b01);
        key_cmd({16'h0001, KEYS[47:0]});
        rchk(REG_SEC, 32'h19);
        key_cmd(KEYS);
        rchk(REG_STAT, 32'ha0);
        chk(lock_state_o, 2'b01);
        do_reset();
        wb_cycle(1'b1, REG_PROT, 32'h1);
        b0 = busy_cnt;
        key_cmd(KEYS);
        chk(lock_state_o, LOCK_OPEN);
        chk(busy_cnt - b0, 1);
        rchk(REG_PROT, 32'h1);
        rchk(REG_SEC, 32'h0a);
        do_reset();
        chk(lock_state_o, 2'b01);
        $display("test key done");
        // An erased stored key never matches, even when presented as-is.
        stored_keys_i <= {KEYS[63:16], KEY_BAD_LO};
        do_reset();
        key_cmd({KEYS[63:16], KEY_BAD_LO});
        chk(lock_state_o, 2'b01);
        // Keys disabled in the security byte: command refused.
        stored_keys_i <= KEYS;
        sec_byte_i <= 8'h01;
        do_reset();
        key_cmd(KEYS);
        rchk(REG_STAT, 32'ha0);
        chk(lock_state_o, 2'b01);
        $display("test key_guard done");
        end_sim();
    end
endmodule
`default_nettype wire
